// file: ppm_port_phy_manager.sv
// port phy manager: idle and request-wait handling of connection opens
// assumes messages and confirmations are one-cycle pulses on one clock
`timescale 1ns/1ps
module ppm_port_phy_manager
  import ppm_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic ssp_target,
  input wire logic stp_target,
  input wire logic smp_target,
  input wire logic [TMR_W-1:0] ssp_bus_inact_cfg,
  input wire logic [TMR_W-1:0] stp_bus_inact_cfg,
  input wire logic [TMR_W-1:0] ssp_max_conn_cfg,
  input wire logic [TMR_W-1:0] stp_max_conn_cfg,
  input wire logic phy_enabled,
  input wire logic phy_disabled,
  input wire logic tx_open,
  input wire logic in_init,
  input wire logic [PROTO_W-1:0] in_proto,
  input wire logic [RATE_W-1:0] in_rate,
  input wire logic [TAG_W-1:0] in_tag,
  input wire logic [ADDR_W-1:0] in_dest,
  input wire logic [ADDR_W-1:0] in_src,
  input wire logic [PBC_W-1:0] in_pbc,
  input wire logic [AWT_W-1:0] in_awt,
  input wire logic cancel_open,
  input wire logic conn_opened,
  input wire logic conn_by_us,
  input wire logic [ADDR_W-1:0] conn_peer,
  input wire logic open_failed,
  input wire logic [3:0] fail_reason,
  input wire logic inbound_rejected,
  input wire logic hard_reset_rcvd,
  output logic [1:0] state_out,
  output logic open_req,
  output logic stop_arb_req,
  output logic req_init,
  output logic [PROTO_W-1:0] req_proto,
  output logic [RATE_W-1:0] req_rate,
  output logic [TAG_W-1:0] req_tag,
  output logic [ADDR_W-1:0] req_dest,
  output logic [ADDR_W-1:0] req_src,
  output logic [PBC_W-1:0] req_pbc,
  output logic [AWT_W-1:0] req_awt,
  output logic opened_msg,
  output logic retry_msg,
  output logic unable_msg,
  output logic [RSN_W-1:0] msg_reason,
  output logic [TMR_W-1:0] bus_inact_init,
  output logic [TMR_W-1:0] max_conn_init
);
  ppm_state_t state_ff, nxt_state;
  logic phy_en_ff, open_seen_ff, opened_seen_ff, issue_ff;
  logic open_req_ff, stop_arb_ff, opened_ff, retry_ff, unable_ff;
  logic [RSN_W-1:0] reason_ff;
  logic [AWT_W-1:0] awt_out_ff;
  logic [TMR_W-1:0] bi_ff, mc_ff;
  logic [1:0] st_ff;
  logic in_wait, fail_retry, fail_unable, fail_close, do_retry;
  logic [RSN_W-1:0] rsn;

  ppm_tmr_if tif();

  ppm_awt_timer u_awt (
    .clock(clock),
    .rst(rst),
    .t(tif.tmr)
  );

  // failure classes; the reason code is passed through unchanged
  function automatic logic [1:0] fail_class(input logic [3:0] r);
    unique case (r)
      OF_PATHWAY_BLOCKED, OF_RETRY, OF_NO_DEST: fail_class = 2'h1;
      OF_BAD_DEST, OF_RATE_NOT_SUP, OF_PROTO_NOT_SUP,
      OF_STP_BUSY, OF_WRONG_DEST: fail_class = 2'h2;
      OF_OPEN_TIMEOUT, OF_BREAK_RCVD, OF_PORT_REQ: fail_class = 2'h3;
      default: fail_class = 2'h0;
    endcase
  endfunction

  assign in_wait = (state_ff == MGR_REQ_WAIT);
  assign fail_retry = open_failed && fail_class(fail_reason) == 2'h1;
  assign fail_unable = open_failed && fail_class(fail_reason) == 2'h2;
  assign fail_close = open_failed && fail_class(fail_reason) == 2'h3;
  // inbound reject only counts once our open request has gone out
  assign do_retry = in_wait && !hard_reset_rcvd && !phy_disabled &&
                    ((conn_opened && !conn_by_us) || fail_retry ||
                     (inbound_rejected && issue_ff));

  always_comb begin
    rsn = fail_reason;
    if (conn_opened && !conn_by_us) begin
      rsn = (conn_peer == req_dest) ? RT_OPENED_BY_DEST
                                    : RT_OPENED_BY_OTHER;
    end else if (inbound_rejected && !open_failed) begin
      rsn = RT_COLLIDED;
    end
  end

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      MGR_IDLE: begin
        if (conn_opened) begin
          nxt_state = MGR_CONNECTED;
        end else if ((phy_en_ff || phy_enabled) &&
                     (open_seen_ff || tx_open)) begin
          nxt_state = MGR_REQ_WAIT;
        end
      end
      MGR_REQ_WAIT: begin
        if (hard_reset_rcvd || phy_disabled) begin
          nxt_state = MGR_IDLE;
        end else if (conn_opened) begin
          nxt_state = MGR_CONNECTED;
        end else if (fail_close) begin
          nxt_state = MGR_CLOSE_WAIT;
        end else if (do_retry || fail_unable) begin
          nxt_state = MGR_IDLE;
        end
      end
      MGR_CONNECTED: nxt_state = MGR_CONNECTED;
      MGR_CLOSE_WAIT: nxt_state = MGR_CLOSE_WAIT;
    endcase
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_ff <= MGR_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // phy enable and tx open may arrive in either order while idle
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      phy_en_ff <= 1'b0;
      open_seen_ff <= 1'b0;
    end else begin
      if (phy_disabled) begin
        phy_en_ff <= 1'b0;
      end else if (phy_enabled) begin
        phy_en_ff <= 1'b1;
      end
      if (state_ff == MGR_IDLE && nxt_state == MGR_REQ_WAIT) begin
        open_seen_ff <= 1'b0;
      end else if (state_ff == MGR_IDLE && tx_open) begin
        open_seen_ff <= 1'b1;
      end
    end
  end

  // tx open values captured once, reused by open request and messages
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      req_init <= 1'b0;
      req_proto <= 3'h0;
      req_rate <= 4'h0;
      req_tag <= 16'h0;
      req_dest <= 64'h0;
      req_src <= 64'h0;
      req_pbc <= 8'h0;
    end else if (state_ff == MGR_IDLE && tx_open) begin
      req_init <= in_init;
      req_proto <= in_proto;
      req_rate <= in_rate;
      req_tag <= in_tag;
      req_dest <= in_dest;
      req_src <= in_src;
      req_pbc <= in_pbc;
    end
  end

  logic [AWT_W-1:0] awt_hold_ff;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      awt_hold_ff <= 15'h0;
    end else if (state_ff == MGR_IDLE && tx_open) begin
      awt_hold_ff <= in_awt;
    end
  end

  // timer loads on entry; open request goes one cycle later
  assign tif.load = (state_ff != MGR_REQ_WAIT) &&
                    (nxt_state == MGR_REQ_WAIT);
  assign tif.init = (state_ff == MGR_IDLE && tx_open) ? in_awt
                                                        : awt_hold_ff;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      issue_ff <= 1'b0;
      open_req_ff <= 1'b0;
      awt_out_ff <= 15'h0;
    end else begin
      open_req_ff <= 1'b0;
      if (!in_wait) begin
        issue_ff <= 1'b0;
      end else if (!issue_ff && !hard_reset_rcvd) begin
        issue_ff <= 1'b1;
        open_req_ff <= 1'b1;
      end
      if (do_retry) begin
        awt_out_ff <= tif.value;
      end else if (in_wait && !issue_ff) begin
        awt_out_ff <= awt_hold_ff;
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      opened_seen_ff <= 1'b0;
      stop_arb_ff <= 1'b0;
    end else begin
      stop_arb_ff <= in_wait && cancel_open && !opened_seen_ff &&
                     !conn_opened;
      if (!in_wait) begin
        opened_seen_ff <= 1'b0;
      end else if (conn_opened) begin
        opened_seen_ff <= 1'b1;
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      opened_ff <= 1'b0;
      retry_ff <= 1'b0;
      unable_ff <= 1'b0;
      reason_ff <= 4'h0;
    end else begin
      opened_ff <= in_wait && conn_opened && !hard_reset_rcvd &&
                   !phy_disabled;
      retry_ff <= do_retry;
      unable_ff <= in_wait && fail_unable && !hard_reset_rcvd &&
                   !phy_disabled;
      if (do_retry || fail_unable) begin
        reason_ff <= rsn;
      end
    end
  end

  // limit values follow the port's target role, but smp_target selects the stp max connect value
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      bi_ff <= 16'h0;
      mc_ff <= 16'h0;
    end else begin
      bi_ff <= ssp_target ? ssp_bus_inact_cfg :
               stp_target ? stp_bus_inact_cfg : 16'h0;
      mc_ff <= ssp_target ? ssp_max_conn_cfg :
               smp_target ? stp_max_conn_cfg : 16'h0;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      st_ff <= 2'h0;
    end else begin
      st_ff <= nxt_state;
    end
  end

  assign state_out = st_ff;
  assign open_req = open_req_ff;
  assign stop_arb_req = stop_arb_ff;
  assign req_awt = awt_out_ff;
  assign opened_msg = opened_ff;
  assign retry_msg = retry_ff;
  assign unable_msg = unable_ff;
  assign msg_reason = reason_ff;
  assign bus_inact_init = bi_ff;
  assign max_conn_init = mc_ff;

  a_reset_idle: assert property (@(posedge clock)
    $fell(rst) |-> st_ff == 2'h0)
    else $error("not idle after reset");
  a_enter_wait: assert property (@(posedge clock) disable iff (rst)
    (state_ff == MGR_IDLE && !conn_opened && phy_en_ff && open_seen_ff)
    |=> state_ff == MGR_REQ_WAIT)
    else $error("idle did not enter request wait");
  a_idle_conn: assert property (@(posedge clock) disable iff (rst)
    (state_ff == MGR_IDLE && conn_opened) |=> state_ff == MGR_CONNECTED)
    else $error("idle did not go connected");
  a_open_issue: assert property (@(posedge clock) disable iff (rst)
    (state_ff == MGR_IDLE && nxt_state == MGR_REQ_WAIT) |=>
    (!in_wait || hard_reset_rcvd) or (##1 open_req))
    else $error("open request not issued");
  a_timer_init: assert property (@(posedge clock) disable iff (rst)
    tif.load |=> tif.value == $past(tif.init))
    else $error("arb timer not loaded");
  a_hard_reset: assert property (@(posedge clock) disable iff (rst)
    (in_wait && hard_reset_rcvd) |=> state_ff == MGR_IDLE && !retry_ff)
    else $error("hard reset not handled");
  a_opened_msg: assert property (@(posedge clock) disable iff (rst)
    (in_wait && conn_opened && !hard_reset_rcvd && !phy_disabled)
    |=> opened_msg && state_ff == MGR_CONNECTED)
    else $error("opened message missing");
  a_retry_awt: assert property (@(posedge clock) disable iff (rst)
    do_retry |=> retry_msg && req_awt == $past(tif.value))
    else $error("retry arb time wrong");
  a_collided: assert property (@(posedge clock) disable iff (rst)
    (do_retry && inbound_rejected && !open_failed && !conn_opened)
    |=> msg_reason == RT_COLLIDED)
    else $error("collided reason wrong");
  a_stop_arb: assert property (@(posedge clock) disable iff (rst)
    (in_wait && cancel_open && !opened_seen_ff && !conn_opened)
    |=> stop_arb_req)
    else $error("stop arb missing");
  a_close_wait: assert property (@(posedge clock) disable iff (rst)
    (in_wait && fail_close && !conn_opened && !hard_reset_rcvd &&
     !phy_disabled) |=> state_ff == MGR_CLOSE_WAIT)
    else $error("close wait not entered");
  a_unable_msg: assert property (@(posedge clock) disable iff (rst)
    (in_wait && fail_unable && !conn_opened && !hard_reset_rcvd &&
     !phy_disabled) |=> unable_msg && state_ff == MGR_IDLE)
    else $error("unable message missing");
  a_retry_fail: assert property (@(posedge clock) disable iff (rst)
    (in_wait && fail_retry && !conn_opened && !hard_reset_rcvd &&
     !phy_disabled) |=> retry_msg && msg_reason == $past(fail_reason))
    else $error("retry reason wrong");
  a_limit_ssp: assert property (@(posedge clock) disable iff (rst)
    ssp_target |=> bus_inact_init == $past(ssp_bus_inact_cfg) &&
    max_conn_init == $past(ssp_max_conn_cfg))
    else $error("ssp limit values wrong");
endmodule

// file: ppm_pkg.sv
// port phy manager package: states, reasons, field widths, tick timing
// assumes a 10 MHz block clock
package ppm_pkg;
  localparam int CLK_HZ = 10000000;
  localparam int TICK_US = 1;
  localparam int TICK_CYCLES = (CLK_HZ / 1000000) * TICK_US;
  localparam int TICK_W = 4;
  localparam int AWT_W = 15;
  localparam int TMR_W = 16;
  localparam int ADDR_W = 64;
  localparam int PROTO_W = 3;
  localparam int RATE_W = 4;
  localparam int TAG_W = 16;
  localparam int PBC_W = 8;
  localparam int RSN_W = 4;
  localparam logic [AWT_W-1:0] AWT_MAX = 15'h7fff;

  typedef enum logic [1:0] {
    MGR_IDLE = 2'h0,
    MGR_REQ_WAIT = 2'h1,
    MGR_CONNECTED = 2'h2,
    MGR_CLOSE_WAIT = 2'h3
  } ppm_state_t;

  // open failed reasons from the link layer
  typedef enum logic [3:0] {
    OF_PATHWAY_BLOCKED = 4'h0,
    OF_RETRY = 4'h1,
    OF_NO_DEST = 4'h2,
    OF_BAD_DEST = 4'h3,
    OF_RATE_NOT_SUP = 4'h4,
    OF_PROTO_NOT_SUP = 4'h5,
    OF_STP_BUSY = 4'h6,
    OF_WRONG_DEST = 4'h7,
    OF_OPEN_TIMEOUT = 4'h8,
    OF_BREAK_RCVD = 4'h9,
    OF_PORT_REQ = 4'ha
  } ppm_fail_t;

  // retry reasons toward overall control
  localparam logic [RSN_W-1:0] RT_PATHWAY_BLOCKED = 4'h0;
  localparam logic [RSN_W-1:0] RT_RETRY = 4'h1;
  localparam logic [RSN_W-1:0] RT_NO_DEST = 4'h2;
  localparam logic [RSN_W-1:0] RT_OPENED_BY_DEST = 4'h3;
  localparam logic [RSN_W-1:0] RT_OPENED_BY_OTHER = 4'h4;
  localparam logic [RSN_W-1:0] RT_COLLIDED = 4'h5;
endpackage

// file: ppm_tmr_if.sv
// link between the manager and its arbitration wait timer
// assumes one clock shared by both ends
`timescale 1ns/1ps
interface ppm_tmr_if;
  import ppm_pkg::*;
  logic load;
  logic [AWT_W-1:0] init;
  logic [AWT_W-1:0] value;
  modport mgr(output load, output init, input value);
  modport tmr(input load, input init, output value);
endinterface

// file: ppm_awt_timer.sv
// arbitration wait timer: counts up one per tick from a loaded value
// assumes load is a one-cycle pulse from the manager
`timescale 1ns/1ps
module ppm_awt_timer
  import ppm_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  ppm_tmr_if.tmr t
);
  logic [TICK_W-1:0] tick_cnt_ff;
  logic [AWT_W-1:0] value_ff;
  logic tick;

  assign tick = (tick_cnt_ff == TICK_W'(TICK_CYCLES - 1));
  assign t.value = value_ff;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      tick_cnt_ff <= 4'h0;
    end else if (t.load || tick) begin
      tick_cnt_ff <= 4'h0;
    end else begin
      tick_cnt_ff <= tick_cnt_ff + 4'h1;
    end
  end

  // saturates instead of wrapping so a long wait never looks short
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      value_ff <= 15'h0;
    end else if (t.load) begin
      value_ff <= t.init;
    end else if (tick && value_ff != AWT_MAX) begin
      value_ff <= value_ff + 15'h1;
    end
  end
endmodule

// file: ppm_link_model.sv
// link layer stand-in: at most one confirmation per open request or kick
// assumes kind, reason and delay are set by the bench before the trigger
`timescale 1ns/1ps
module ppm_link_model
  import ppm_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic open_req,
  input wire logic kick,
  input wire logic [2:0] kind,
  input wire logic [3:0] reason,
  input wire logic [7:0] dly,
  input wire logic [ADDR_W-1:0] req_dest,
  output logic conn_opened,
  output logic conn_by_us,
  output logic [ADDR_W-1:0] conn_peer,
  output logic open_failed,
  output logic [3:0] fail_reason,
  output logic inbound_rejected,
  output logic hard_reset_rcvd,
  output logic phy_disabled
);
  logic armed_ff;
  logic tog_ff;
  logic [7:0] cnt_ff;
  logic fire;
  // kind: 1 fail, 2 ours, 3 by dest, 4 by other, 5 reject, 6 hard reset,
  // 7 phy off; 0 stays silent so the bench can cancel meanwhile
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      armed_ff <= 1'b0;
      cnt_ff <= 8'h00;
    end else if (open_req || kick) begin
      armed_ff <= 1'b1;
      cnt_ff <= dly;
    end else if (cnt_ff != 8'h00) begin
      cnt_ff <= cnt_ff - 8'h01;
    end else begin
      armed_ff <= 1'b0;
    end
  end
  // released lines toggle so a stale value never passes for a live one
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      tog_ff <= 1'b0;
    end else begin
      tog_ff <= ~tog_ff;
    end
  end
  assign fire = armed_ff && (cnt_ff == 8'h00);
  assign open_failed = fire && (kind == 3'h1);
  assign conn_opened = fire && (kind >= 3'h2) && (kind <= 3'h4);
  assign conn_by_us = conn_opened ? (kind == 3'h2) : tog_ff;
  assign conn_peer = !conn_opened ? {ADDR_W{tog_ff}} :
                     (kind == 3'h4) ? ~req_dest : req_dest;
  assign fail_reason = open_failed ? reason : {4{tog_ff}};
  assign inbound_rejected = fire && (kind == 3'h5);
  assign hard_reset_rcvd = fire && (kind == 3'h6);
  assign phy_disabled = fire && (kind == 3'h7);
endmodule

// file: testbench.sv
// bench for the port phy manager against the link layer stand-in
// assumes the package, interface and design files are compiled first
`timescale 1ns/1ps
module testbench;
  import ppm_pkg::*;
  localparam logic [ADDR_W-1:0] DST = 64'h5000_0000_0000_00a1;
  localparam logic [ADDR_W-1:0] SRC = 64'h5000_0000_0000_00b2;
  logic clock, rst, ssp_target, stp_target, smp_target;
  logic phy_enabled, tx_open, in_init, cancel_open, kick;
  logic [PROTO_W-1:0] in_proto, req_proto;
  logic [RATE_W-1:0] in_rate, req_rate;
  logic [TAG_W-1:0] in_tag, req_tag;
  logic [ADDR_W-1:0] in_dest, in_src, conn_peer, req_dest, req_src;
  logic [PBC_W-1:0] in_pbc, req_pbc;
  logic [AWT_W-1:0] in_awt, req_awt;
  logic [TMR_W-1:0] bus_inact_init, max_conn_init;
  logic [2:0] kind;
  logic [3:0] reason, fail_reason;
  logic [7:0] dly;
  logic conn_opened, conn_by_us, open_failed, inbound_rejected;
  logic hard_reset_rcvd, phy_disabled, open_req, stop_arb_req, req_init;
  logic opened_msg, retry_msg, unable_msg;
  logic [1:0] state_out;
  logic [RSN_W-1:0] msg_reason;
  int n_errors, checks;
  wire [4:0] outs = {stop_arb_req, opened_msg, unable_msg, retry_msg,
                     open_req};
  wire [159:0] got7 = {req_init, req_proto, req_rate, req_tag, req_dest,
                       req_src, req_pbc};
  localparam logic [159:0] EXP7 = {1'b1, 3'h1, 4'h9, 16'h3c5a, DST, SRC,
                                   8'h07};

  ppm_port_phy_manager dut_u (
    .clock, .rst, .ssp_target, .stp_target, .smp_target,
    .ssp_bus_inact_cfg(16'h1111), .stp_bus_inact_cfg(16'h2222),
    .ssp_max_conn_cfg(16'h3333), .stp_max_conn_cfg(16'h4444),
    .phy_enabled, .phy_disabled, .tx_open, .in_init, .in_proto, .in_rate,
    .in_tag, .in_dest, .in_src, .in_pbc, .in_awt, .cancel_open,
    .conn_opened, .conn_by_us, .conn_peer, .open_failed, .fail_reason,
    .inbound_rejected, .hard_reset_rcvd, .state_out, .open_req,
    .stop_arb_req, .req_init, .req_proto, .req_rate, .req_tag, .req_dest,
    .req_src, .req_pbc, .req_awt, .opened_msg, .retry_msg, .unable_msg,
    .msg_reason, .bus_inact_init, .max_conn_init
  );
  ppm_link_model link_u (
    .clock, .rst, .open_req, .kick, .kind, .reason, .dly, .req_dest,
    .conn_opened, .conn_by_us, .conn_peer, .open_failed, .fail_reason,
    .inbound_rejected, .hard_reset_rcvd, .phy_disabled
  );

  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  task automatic close_out;
    if (n_errors == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input logic [191:0] got, input logic [191:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // samples just after the current edge first, so a pulse is never missed
  task automatic wait_out(input int w);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < 100 && !hit; i++) begin
      #1;
      hit = (outs[w] === 1'b1);
      if (!hit) @(posedge clock);
    end
    if (!hit) begin
      n_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, outs, w);
      close_out;
    end
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  task automatic do_reset;
    @(posedge clock);
    rst <= 1'b1;
    repeat (6) @(posedge clock);
    rst <= 1'b0;
  endtask

  task automatic do_open(input logic [2:0] k, input logic [3:0] r,
                         input logic [7:0] d, input logic [AWT_W-1:0] a);
    @(posedge clock);
    kind <= k;
    reason <= r;
    dly <= d;
    in_awt <= a;
    tx_open <= 1'b1;
    phy_enabled <= 1'b1;
    @(posedge clock);
    tx_open <= 1'b0;
    phy_enabled <= 1'b0;
    wait_out(0);
    chk(state_out, 2'h1);
    chk({got7, req_awt}, {EXP7, a});
  endtask

  task automatic s_roles;
    chk({state_out, outs}, '0);
    @(posedge clock);
    ssp_target <= 1'b1;
    settle(3);
    chk({bus_inact_init, max_conn_init}, 32'h1111_3333);
    @(posedge clock);
    ssp_target <= 1'b0;
    stp_target <= 1'b1;
    settle(3);
    chk(bus_inact_init, 16'h2222);
    @(posedge clock);
    stp_target <= 1'b0;
    smp_target <= 1'b1;
    settle(3);
    chk(max_conn_init, 16'h4444);
  endtask

  // open alone must wait for the phy, then a phy loss ends the request
  task automatic s_gate;
    @(posedge clock);
    tx_open <= 1'b1;
    kind <= 3'h7;
    @(posedge clock);
    tx_open <= 1'b0;
    settle(4);
    chk(state_out, 2'h0);
    @(posedge clock);
    phy_enabled <= 1'b1;
    @(posedge clock);
    phy_enabled <= 1'b0;
    wait_out(0);
    settle(2);
    chk({state_out, outs[3:1]}, 5'h00);
  endtask

  task automatic s_fail;
    for (int c = 0; c < 8; c++) begin
      do_open(3'h1, c[3:0], 8'h00, 15'h0040);
      wait_out(c < 3 ? 1 : 2);
      chk({state_out, outs[2:1], msg_reason},
          {2'h0, (c < 3) ? 2'h1 : 2'h2, c[3:0]});
      if (c < 3) chk(got7, EXP7);
      else chk({req_tag, req_dest, req_src}, {16'h3c5a, DST, SRC});
    end
    for (int c = 8; c < 11; c++) begin
      do_open(3'h1, c[3:0], 8'h00, 15'h0040);
      settle(3);
      chk(state_out, 2'h3);
      do_reset;
    end
  endtask

  task automatic s_opened;
    do_open(3'h2, 4'h0, 8'h02, 15'h0040);
    wait_out(3);
    chk({state_out, retry_msg}, {2'h2, 1'b0});
    do_reset;
    for (int k = 3; k < 5; k++) begin
      do_open(k[2:0], 4'h0, 8'h01, 15'h0040);
      wait_out(1);
      chk({opened_msg, msg_reason}, {1'b1, (k == 3) ? RT_OPENED_BY_DEST :
          RT_OPENED_BY_OTHER});
      chk(got7, EXP7);
      do_reset;
    end
  endtask

  // a late collision lets the timer run about three ticks, then saturate
  task automatic s_collide;
    logic [AWT_W-1:0] v;
    do_open(3'h5, 4'h0, 8'h25, 15'h0100);
    wait_out(1);
    v = req_awt;
    chk({state_out, msg_reason}, {2'h0, RT_COLLIDED});
    chk(v >= 15'h0103 && v <= 15'h0105, 1'b1);
    do_open(3'h5, 4'h0, 8'h25, 15'h7ffe);
    wait_out(1);
    chk(req_awt, AWT_MAX);
  endtask

  task automatic s_cancel;
    do_open(3'h0, 4'h0, 8'h00, 15'h0040);
    @(posedge clock);
    cancel_open <= 1'b1;
    @(posedge clock);
    cancel_open <= 1'b0;
    wait_out(4);
    @(posedge clock);
    kind <= 3'h6;
    kick <= 1'b1;
    @(posedge clock);
    kick <= 1'b0;
    settle(1);
    chk({state_out, outs[3:1]}, 5'h00);
    @(posedge clock);
    kind <= 3'h2;
    kick <= 1'b1;
    @(posedge clock);
    kick <= 1'b0;
    settle(3);
    chk(state_out, 2'h2);
  endtask

  initial begin
    rst = 1'b1;
    {ssp_target, stp_target, smp_target, phy_enabled, tx_open} = 5'h00;
    {cancel_open, kick, kind, reason, dly} = '0;
    in_init = 1'b1;
    in_proto = 3'h1;
    in_rate = 4'h9;
    in_tag = 16'h3c5a;
    in_dest = DST;
    in_src = SRC;
    in_pbc = 8'h07;
    in_awt = 15'h0040;
    n_errors = 0;
    checks = 0;
    repeat (6) @(posedge clock);
    rst <= 1'b0;
    s_roles;
    s_gate;
    s_fail;
    s_opened;
    s_collide;
    s_cancel;
    close_out;
  end
endmodule
